// ==== verilog/dss_setpoint_selector.v ====
// Purpose: Per-buck setpoint storage, selection and target ramp generation.
// Assumes: All inputs synchronous to CLK except select pins, which are synchronised.
// Notes: The analog loop consumes OUT_CODE; one code step per rate period.
`timescale 1ns/1ps
`default_nettype none
`include "dss_defines.vh"

module dss_setpoint_selector #(
   parameter integer WDOG_DEBOUNCE_CYC = `DSS_WDOG_DEBOUNCE_CYC,
   parameter integer STEP_BASE_CYC     = `DSS_STEP_BASE_CYC
) (
   // Clock and reset
   input  wire        CLK,
   input  wire        RESET_N,
   // Setpoint write port
   input  wire        WR_HIGH,
   input  wire        WR_LOW,
   input  wire [1:0]  WR_BUCK,
   input  wire [1:0]  WR_INDEX,
   input  wire [7:0]  WR_DATA,
   // One-time memory image
   input  wire        BOOT_LOAD,
   input  wire [159:0] OTP_SETPOINTS,
   // Selection configuration
   input  wire [2:0]  PIN_FUNCTION_MODE,
   input  wire [3:0]  SELECTION_SOURCE,
   input  wire [7:0]  SETPOINT_POINTER,
   input  wire [7:0]  SHARED_PIN_ROUTE,
   input  wire [7:0]  GLOBAL_PIN_DECODE,
   // Ramp configuration
   input  wire [11:0] POWERUP_RAMP_RATE,
   input  wire [11:0] POWERDOWN_RAMP_RATE,
   input  wire [11:0] TRANSITION_RISE_RATE,
   input  wire [11:0] TRANSITION_FALL_RATE,
   input  wire [7:0]  FEEDBACK_DIVIDER,
   input  wire [3:0]  BUCK_ENABLE,
   // Watchdog
   input  wire        WATCHDOG_INPUT,
   input  wire        WATCHDOG_ACTIVE_LOW,
   input  wire [3:0]  WATCHDOG_BUCK_MASK,
   // Pins
   input  wire [3:0]  MULTI_PURPOSE_PIN_IN,
   input  wire [2:0]  GPIO_IN,
   input  wire [1:0]  POWER_GOOD,
   output wire [3:0]  MULTI_PURPOSE_PIN_OUT,
   output wire [3:0]  MULTI_PURPOSE_PIN_OE,
   // Status
   output wire [39:0] TARGET_CODE,
   output wire [39:0] OUT_CODE,
   output wire [7:0]  ACTIVE_SETPOINT,
   output wire [3:0]  RAMP_BUSY,
   output wire        WATCHDOG_RESTORE
);

   localparam [3:0] PH_IDLE  = 4'h1;
   localparam [3:0] PH_PWRUP = 4'h2;
   localparam [3:0] PH_TRANS = 4'h4;
   localparam [3:0] PH_PWRDN = 4'h8;
   localparam [15:0] STEP_BASE = STEP_BASE_CYC[15:0];
   localparam [23:0] WDOG_LIMIT = WDOG_DEBOUNCE_CYC[23:0];

   // Cycles per code step; a slower divider ratio scales the period up.
   function [15:0] rate_period;
      input [2:0] code;
      input [1:0] fb_div;
      reg   [15:0] scaled;
      begin
         scaled      = STEP_BASE * ({14'h0000, fb_div} + 16'h0001);
         rate_period = scaled << code;
      end
   endfunction

   // Active setpoint index of one buck from source, pins and pointer.
   function [1:0] pick_index;
      input       src;
      input [2:0] mode;
      input [1:0] bk;
      input [1:0] route;
      input [1:0] dec;
      input [3:0] mp;
      input [2:0] gp;
      input [1:0] ptr;
      begin
         pick_index = ptr;
         if (src == `DSS_SRC_PINS) begin
            case (mode)
               `DSS_MODE_SHARED: begin
                  if (route == `DSS_ROUTE_A)
                     pick_index = {1'b0, gp[0]};
                  else if (route == `DSS_ROUTE_B)
                     pick_index = {1'b0, gp[1]};
                  else if (route == `DSS_ROUTE_C)
                     pick_index = {1'b0, gp[2]};
                  else
                     pick_index = ptr;
               end
               `DSS_MODE_GLOBAL: begin
                  case (dec)
                     2'h0:    pick_index = 2'h0;
                     2'h1:    pick_index = {1'b0, mp[1]};
                     2'h2:    pick_index = {mp[0], 1'b0};
                     default: pick_index = {mp[0], mp[1]};
                  endcase
               end
               `DSS_MODE_DUAL2: begin
                  if (bk == 2'h0)
                     pick_index = {mp[1], mp[0]};
                  else if (bk == 2'h1)
                     pick_index = {mp[3], mp[2]};
                  else
                     pick_index = ptr;
               end
               `DSS_MODE_MIXED: begin
                  if (bk == 2'h0)
                     pick_index = {mp[1], mp[0]};
                  else if (bk == 2'h1)
                     pick_index = {1'b0, mp[2]};
                  else if (bk == 2'h2)
                     pick_index = {1'b0, mp[3]};
                  else
                     pick_index = ptr;
               end
               `DSS_MODE_SINGLE4: begin
                  pick_index = {1'b0, mp[bk]};
               end
               default: begin
                  pick_index = ptr;
               end
            endcase
         end
      end
   endfunction

   // Setpoint store and staged high bytes, index = buck*4 + setpoint.
   reg [9:0]  sp_r [0:15];
   reg [7:0]  hi_r [0:15];
   reg [3:0]  mp_s1_r;
   reg [3:0]  mp_s2_r;
   reg [2:0]  gp_s1_r;
   reg [2:0]  gp_s2_r;
   reg [39:0] tgt_r;
   reg [39:0] cur_r;
   reg [7:0]  act_r;
   reg [3:0]  busy_r;
   reg [3:0]  ovr_r;
   reg [3:0]  en_d_r;
   reg [15:0] cnt_r [0:3];
   reg [3:0]  ph_r [0:3];
   reg [23:0] wd_cnt_r;
   reg        wd_done_r;
   reg        wd_pulse_r;
   reg [3:0]  mp_out_r;
   reg [3:0]  mp_oe_r;

   wire       wd_active = WATCHDOG_INPUT ^ WATCHDOG_ACTIVE_LOW;
   wire [3:0] wr_addr   = {WR_BUCK, WR_INDEX};
   wire       wd_fire   = wd_active && !wd_done_r && (wd_cnt_r == WDOG_LIMIT - 24'h000001);

   integer i;
   integer b;

   // Two-flop synchronisers; stage one feeds only stage two.
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mp_s1_r <= 4'h0;
         mp_s2_r <= 4'h0;
         gp_s1_r <= 3'h0;
         gp_s2_r <= 3'h0;
      end else begin
         mp_s1_r <= MULTI_PURPOSE_PIN_IN;
         mp_s2_r <= mp_s1_r;
         gp_s1_r <= GPIO_IN;
         gp_s2_r <= gp_s1_r;
      end
   end

   // Setpoint storage: boot load, then host writes committed by the low bits.
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         for (i = 0; i < 16; i = i + 1) begin
            sp_r[i] <= `DSS_CODE_RESET;
            hi_r[i] <= 8'h00;
         end
      end else if (BOOT_LOAD) begin
         for (i = 0; i < 16; i = i + 1) begin
            sp_r[i] <= OTP_SETPOINTS[i*10 +: 10];
            hi_r[i] <= OTP_SETPOINTS[i*10+2 +: 8];
         end
      end else begin
         if (wd_fire) begin
            for (i = 0; i < 4; i = i + 1) begin
               if (WATCHDOG_BUCK_MASK[i]) begin
                  sp_r[i*4] <= OTP_SETPOINTS[i*40 +: 10];
                  hi_r[i*4] <= OTP_SETPOINTS[i*40+2 +: 8];
               end
            end
         end
         if (WR_HIGH)
            hi_r[wr_addr] <= WR_DATA;
         // The high byte only stages; the stored code moves on the low write.
         if (WR_LOW)
            sp_r[wr_addr] <= {hi_r[wr_addr], WR_DATA[1:0]};
      end
   end

   // Watchdog debounce: fires once per assertion that outlasts the window.
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wd_cnt_r   <= 24'h000000;
         wd_done_r  <= 1'b0;
         wd_pulse_r <= 1'b0;
      end else begin
         wd_pulse_r <= wd_fire;
         if (!wd_active) begin
            wd_cnt_r  <= 24'h000000;
            wd_done_r <= 1'b0;
         end else if (wd_fire) begin
            wd_done_r <= 1'b1;
         end else if (!wd_done_r) begin
            wd_cnt_r  <= wd_cnt_r + 24'h000001;
         end
      end
   end

   // Watchdog override forces setpoint 0 until the host commits to that buck.
   // Each process keeps its own loop index so no variable has two drivers.
   always @(posedge CLK or negedge RESET_N) begin : ovr_set
      integer i;
      if (!RESET_N) begin
         ovr_r <= 4'h0;
      end else begin
         for (i = 0; i < 4; i = i + 1) begin
            if (wd_fire && WATCHDOG_BUCK_MASK[i])
               ovr_r[i] <= 1'b1;
            else if (WR_LOW && (WR_BUCK == i[1:0]))
               ovr_r[i] <= 1'b0;
         end
      end
   end

   // Active index and target code per buck.
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         act_r <= 8'h00;
         tgt_r <= 40'h0000000000;
      end else begin
         for (b = 0; b < 4; b = b + 1) begin
            if (ovr_r[b]) begin
               act_r[b*2 +: 2]  <= 2'h0;
               tgt_r[b*10 +: 10] <= sp_r[b*4];
            end else begin
               act_r[b*2 +: 2] <= pick_index(SELECTION_SOURCE[b], PIN_FUNCTION_MODE,
                                             b[1:0], SHARED_PIN_ROUTE[b*2 +: 2],
                                             GLOBAL_PIN_DECODE[b*2 +: 2], mp_s2_r,
                                             gp_s2_r, SETPOINT_POINTER[b*2 +: 2]);
               tgt_r[b*10 +: 10] <= sp_r[b*4 + act_r[b*2 +: 2]];
            end
         end
      end
   end

   // Ramp engine: one code step toward the goal per rate period.
   always @(posedge CLK or negedge RESET_N) begin : ramp
      reg [9:0]  goal;
      reg [9:0]  cur;
      reg [2:0]  code;
      reg [15:0] period;
      // The local index shadows the shared one, so this loop stays single-driven.
      integer    i;
      if (!RESET_N) begin
         cur_r  <= 40'h0000000000;
         busy_r <= 4'h0;
         en_d_r <= 4'h0;
         for (i = 0; i < 4; i = i + 1) begin
            cnt_r[i] <= 16'h0000;
            ph_r[i]  <= PH_IDLE;
         end
      end else begin
         en_d_r <= BUCK_ENABLE;
         for (i = 0; i < 4; i = i + 1) begin
            goal = BUCK_ENABLE[i] ? tgt_r[i*10 +: 10] : `DSS_CODE_RESET;
            cur  = cur_r[i*10 +: 10];
            case (ph_r[i])
               PH_PWRUP: code = POWERUP_RAMP_RATE[i*3 +: 3];
               PH_PWRDN: code = POWERDOWN_RAMP_RATE[i*3 +: 3];
               default:  code = (goal > cur) ? TRANSITION_RISE_RATE[i*3 +: 3]
                                             : TRANSITION_FALL_RATE[i*3 +: 3];
            endcase
            period = rate_period(code, FEEDBACK_DIVIDER[i*2 +: 2]);
            busy_r[i] <= (goal != cur);
            if (BUCK_ENABLE[i] && !en_d_r[i]) begin
               ph_r[i]  <= PH_PWRUP;
               cnt_r[i] <= 16'h0000;
            end else if (!BUCK_ENABLE[i] && en_d_r[i]) begin
               ph_r[i]  <= PH_PWRDN;
               cnt_r[i] <= 16'h0000;
            end else if (goal == cur) begin
               cnt_r[i] <= 16'h0000;
               ph_r[i]  <= BUCK_ENABLE[i] ? PH_TRANS : PH_IDLE;
            end else if (cnt_r[i] >= period - 16'h0001) begin
               // Target moves mid-ramp simply redirect the next step.
               cnt_r[i] <= 16'h0000;
               if (goal > cur)
                  cur_r[i*10 +: 10] <= cur + 10'h001;
               else
                  cur_r[i*10 +: 10] <= cur - 10'h001;
               case (ph_r[i])
                  PH_IDLE:  ph_r[i] <= PH_TRANS;
                  PH_PWRUP: ph_r[i] <= PH_PWRUP;
                  PH_PWRDN: ph_r[i] <= PH_PWRDN;
                  default:  ph_r[i] <= PH_TRANS;
               endcase
            end else begin
               cnt_r[i] <= cnt_r[i] + 16'h0001;
            end
         end
      end
   end

   // Power-good pins are only driven in global select mode.
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mp_out_r <= 4'h0;
         mp_oe_r  <= 4'h0;
      end else if (PIN_FUNCTION_MODE == `DSS_MODE_GLOBAL) begin
         mp_out_r <= {POWER_GOOD[1], POWER_GOOD[0], 2'b00};
         mp_oe_r  <= 4'hC;
      end else begin
         mp_out_r <= 4'h0;
         mp_oe_r  <= 4'h0;
      end
   end

   assign MULTI_PURPOSE_PIN_OUT = mp_out_r;
   assign MULTI_PURPOSE_PIN_OE  = mp_oe_r;
   assign TARGET_CODE      = tgt_r;
   assign OUT_CODE         = cur_r;
   assign ACTIVE_SETPOINT  = act_r;
   assign RAMP_BUSY        = busy_r;
   assign WATCHDOG_RESTORE = wd_pulse_r;

endmodule // dss_setpoint_selector
`default_nettype wire

// ==== verilog/dss_defines.vh ====
// Purpose: Shared constants for the setpoint selector.
// Assumes: 125 MHz clock; flat per-buck fields, buck 0 in the low bits.
`ifndef DSS_DEFINES_VH
`define DSS_DEFINES_VH
`define DSS_SRC_POINTER    1'b0
`define DSS_SRC_PINS       1'b1
`define DSS_MODE_SHARED    3'h3
`define DSS_MODE_GLOBAL    3'h4
`define DSS_MODE_DUAL2     3'h5
`define DSS_MODE_MIXED     3'h6
`define DSS_MODE_SINGLE4   3'h7
`define DSS_ROUTE_A        2'h0
`define DSS_ROUTE_B        2'h1
`define DSS_ROUTE_C        2'h2
`define DSS_ROUTE_REG      2'h3
`define DSS_CODE_W         10
`define DSS_CODE_RESET     10'h000
`define DSS_MP_PIN_GOOD_ONE 2
`define DSS_MP_PIN_GOOD_TWO 3
`define DSS_CLK_KHZ        125000
`define DSS_WDOG_DEBOUNCE_MS 10
`define DSS_WDOG_DEBOUNCE_CYC (`DSS_WDOG_DEBOUNCE_MS * `DSS_CLK_KHZ)
`define DSS_STEP_BASE_CYC  4
`endif

// ==== verification/dss_sva.sv ====
// Purpose: Port-level assertions for the voltage setpoint selector.
// Assumes: Configuration ports are held while the select pins are exercised.
// Notes: Pin checks wait five samples so the two-flop synchroniser can settle.
`timescale 1ns/1ps
`default_nettype none
module dss_sva (
   // Clock and reset
   input wire logic        CLK,
   input wire logic        RESET_N,
   // Configuration and pins
   input wire logic [2:0]  PIN_FUNCTION_MODE,
   input wire logic [2:0]  GPIO_IN,
   input wire logic [3:0]  SELECTION_SOURCE,
   input wire logic [3:0]  WATCHDOG_BUCK_MASK,
   input wire logic [3:0]  MULTI_PURPOSE_PIN_IN,
   input wire logic [7:0]  SETPOINT_POINTER,
   input wire logic [7:0]  SHARED_PIN_ROUTE,
   input wire logic [7:0]  GLOBAL_PIN_DECODE,
   input wire logic [1:0]  POWER_GOOD,
   // Results
   input wire logic [3:0]  MULTI_PURPOSE_PIN_OUT,
   input wire logic [3:0]  MULTI_PURPOSE_PIN_OE,
   input wire logic [39:0] OUT_CODE,
   input wire logic [7:0]  ACTIVE_SETPOINT,
   input wire logic        WATCHDOG_RESTORE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   wire [2:0] md = PIN_FUNCTION_MODE;
   wire [3:0] mp = MULTI_PURPOSE_PIN_IN;
   wire [1:0] a0 = ACTIVE_SETPOINT[1:0];
   wire [9:0] o0 = OUT_CODE[9:0];
   wire       p0 = SELECTION_SOURCE[0];
   a_oe_global: assert property ((md == 3'h4) [*2] |-> MULTI_PURPOSE_PIN_OE == 4'hC)
      else $error("pin enable wrong in global mode");
   a_oe_other: assert property ((md != 3'h4) [*2] |-> MULTI_PURPOSE_PIN_OE == 4'h0)
      else $error("pin enable set outside global mode");
   a_pg_route: assert property ((md == 3'h4 && $stable(POWER_GOOD)) [*2]
      |-> MULTI_PURPOSE_PIN_OUT[3:2] == POWER_GOOD) else $error("power good not routed");
   a_ptr_pick: assert property ((!p0 && $stable(SETPOINT_POINTER)) [*3]
      |-> a0 == SETPOINT_POINTER[1:0]) else $error("pointer not followed");
   a_single_pin: assert property ((md == 3'h7 && p0 && $stable(mp)) [*5]
      |-> a0 == {1'b0, mp[0]}) else $error("single pin select wrong");
   a_sync_delay: assert property ((md == 3'h7 && p0 && $stable(mp[0])) [*4]
      ##1 (md == 3'h7 && p0 && $changed(mp[0])) |=> $stable(a0) ##1 $stable(a0))
      else $error("select pin decoded without two synchroniser stages");
   a_dual_pin: assert property ((md == 3'h5 && p0 && $stable(mp)) [*5]
      |-> a0 == mp[1:0]) else $error("dual pin select wrong");
   a_global_bin: assert property ((md == 3'h4 && SELECTION_SOURCE[3]
      && GLOBAL_PIN_DECODE[7:6] == 2'h3 && $stable(mp)) [*5]
      |-> ACTIVE_SETPOINT[7:6] == {mp[0], mp[1]}) else $error("binary decode wrong");
   a_shared_a: assert property ((md == 3'h3 && p0 && SHARED_PIN_ROUTE[1:0] == 2'h0
      && $stable(GPIO_IN)) [*5] |-> a0 == {1'b0, GPIO_IN[0]}) else $error("shared A wrong");
   a_step_one: assert property ($changed(o0)
      |-> o0 == $past(o0) + 10'h001 || o0 + 10'h001 == $past(o0))
      else $error("output code jumped");
   a_wdog_once: assert property (WATCHDOG_RESTORE |=> !WATCHDOG_RESTORE)
      else $error("restore pulse too long");
   a_wdog_zero: assert property (WATCHDOG_RESTORE && WATCHDOG_BUCK_MASK[3]
      |=> ACTIVE_SETPOINT[7:6] == 2'h0) else $error("restore did not force setpoint 0");
endmodule  // dss_sva
bind dss_setpoint_selector dss_sva u_sva (
   .CLK(CLK), .RESET_N(RESET_N), .PIN_FUNCTION_MODE(PIN_FUNCTION_MODE), .GPIO_IN(GPIO_IN),
   .SELECTION_SOURCE(SELECTION_SOURCE), .WATCHDOG_BUCK_MASK(WATCHDOG_BUCK_MASK),
   .MULTI_PURPOSE_PIN_IN(MULTI_PURPOSE_PIN_IN), .SETPOINT_POINTER(SETPOINT_POINTER),
   .SHARED_PIN_ROUTE(SHARED_PIN_ROUTE), .GLOBAL_PIN_DECODE(GLOBAL_PIN_DECODE),
   .POWER_GOOD(POWER_GOOD), .MULTI_PURPOSE_PIN_OUT(MULTI_PURPOSE_PIN_OUT),
   .MULTI_PURPOSE_PIN_OE(MULTI_PURPOSE_PIN_OE), .OUT_CODE(OUT_CODE),
   .ACTIVE_SETPOINT(ACTIVE_SETPOINT),
   .WATCHDOG_RESTORE(WATCHDOG_RESTORE));
`default_nettype wire

// ==== verification/dss_host_model.sv ====
// Purpose: Host processor model driving the voltage select pins.
// Assumes: Requests come from the bench.
// Notes: Pins are always driven, as a push-pull host output is.
`timescale 1ns/1ps
`default_nettype none
module dss_host_model (
   // Clock and request
   input  wire logic       clk,
   input  wire logic [6:0] req,
   // Select pins
   output var logic [3:0]  mp_pin,
   output var logic [2:0]  gpio
);
   initial {gpio, mp_pin} = 7'h00;
   // Pins move on falling edges so they never race the selector's sampling edge.
   always @(negedge clk) begin
      {gpio, mp_pin} <= req;
   end
endmodule  // dss_host_model
`default_nettype wire

// ==== verification/dss_setpoint_selector_tb.sv ====
// Purpose: Self-checking bench for the voltage setpoint selector.
// Assumes: 125 MHz clock; debounce shortened to WDC cycles.
// Notes: Expected codes follow the boot image formula in code().
`timescale 1ns/1ps
`default_nettype none
module dss_setpoint_selector_tb;
   localparam integer WDC = 20;
   logic         clk, rst_n, wr_hi, wr_lo, boot, wdog_n;
   logic [1:0]   wb, wi, pg;
   logic [2:0]   mode;
   logic [3:0]   src, en, mask;
   logic [7:0]   wd, ptr, route, dec, fbd;
   logic [11:0]  pup, pdn, rise, fall;
   logic [159:0] otp;
   logic [6:0]   pin_req;
   wire  [3:0]   mp_pin, mp_out, mp_oe, busy;
   wire  [2:0]   gpio;
   wire  [39:0]  tgt, out;
   wire  [7:0]   act;
   wire          restore;
   integer       num_errors = 0, checks = 0, k, m;

   dss_host_model host (.clk(clk), .req(pin_req), .mp_pin(mp_pin), .gpio(gpio));
   dss_setpoint_selector #(.WDOG_DEBOUNCE_CYC(WDC), .STEP_BASE_CYC(4)) uut (
      .CLK(clk), .RESET_N(rst_n), .WR_HIGH(wr_hi), .WR_LOW(wr_lo), .WR_BUCK(wb),
      .WR_INDEX(wi), .WR_DATA(wd), .BOOT_LOAD(boot), .OTP_SETPOINTS(otp),
      .PIN_FUNCTION_MODE(mode), .SELECTION_SOURCE(src), .SETPOINT_POINTER(ptr),
      .SHARED_PIN_ROUTE(route), .GLOBAL_PIN_DECODE(dec), .POWERUP_RAMP_RATE(pup),
      .POWERDOWN_RAMP_RATE(pdn), .TRANSITION_RISE_RATE(rise), .TRANSITION_FALL_RATE(fall),
      .FEEDBACK_DIVIDER(fbd), .BUCK_ENABLE(en), .WATCHDOG_INPUT(wdog_n),
      .WATCHDOG_ACTIVE_LOW(1'b1), .WATCHDOG_BUCK_MASK(mask), .GPIO_IN(gpio),
      .MULTI_PURPOSE_PIN_IN(mp_pin), .POWER_GOOD(pg), .MULTI_PURPOSE_PIN_OUT(mp_out),
      .MULTI_PURPOSE_PIN_OE(mp_oe), .TARGET_CODE(tgt),
      .OUT_CODE(out), .ACTIVE_SETPOINT(act), .RAMP_BUSY(busy), .WATCHDOG_RESTORE(restore));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   function automatic logic [9:0] code(input integer n);
      code = 10'(n * 16 + 8);
   endfunction
   function automatic logic [7:0] exp_act(input integer md, input logic [3:0] p,
                                          input logic [2:0] g);
      case (md)
         3: exp_act = {2'h3, 1'b0, g[2], 1'b0, g[1], 1'b0, g[0]};
         4: exp_act = {p[0], p[1], p[0], 2'h0, p[1], 2'h0};
         5: exp_act = {4'hE, p};
         6: exp_act = {2'h3, 1'b0, p[3], 1'b0, p[2], p[1], p[0]};
         default: exp_act = {1'b0, p[3], 1'b0, p[2], 1'b0, p[1], 1'b0, p[0]};
      endcase
   endfunction
   task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h got %h", n, e, g);
      end
   endtask
   // Strobes are set once per falling edge, so consecutive calls never double-drive them.
   task automatic wr(input logic [1:0] s, input logic [1:0] b, i, input logic [7:0] d);
      {wr_hi, wr_lo, wb, wi, wd} = {s, b, i, d};
      @(negedge clk);
   endtask
   task automatic gap(input integer e);
      integer n = 0, c = 0, t = 0;
      logic [9:0] o;
      while (n < 3 && c < 3000) begin
         o = out[9:0];
         @(negedge clk);
         c++;
         if (out[9:0] !== o) n++;
         if (out[9:0] !== o && n == 2) t = c;
      end
      chk("step_gap", e, c - t);
   endtask
   task automatic idle(input logic [9:0] e);
      for (k = 0; k < 3000 && busy[0] !== 1'b0; k++) @(negedge clk);
      repeat (2) @(negedge clk);
      chk("out_settled", e, out[9:0]);
      chk("busy", 1'b0, busy[0]);
   endtask
   task automatic t_boot;
      for (k = 0; k < 16; k++) otp[k*10 +: 10] = code(k);
      boot = 1'b1;
      @(negedge clk);
      boot = 1'b0;
      for (m = 0; m < 4; m++) begin
         ptr = {4{m[1:0]}};
         repeat (4) @(negedge clk);
         chk("active", {4{m[1:0]}}, act);
         chk("target", {code(12 + m), code(8 + m), code(4 + m), code(m)}, tgt);
      end
      $display("boot and pointer test done");
   endtask
   task automatic t_write;
      ptr = 8'h55;
      wr(2'b10, 2'h1, 2'h1, 8'hA5);
      wr(2'b00, 2'h1, 2'h1, 8'h00);
      repeat (3) @(negedge clk);
      chk("target_held", code(5), tgt[19:10]);
      wr(2'b01, 2'h1, 2'h1, 8'h02);
      wr(2'b01, 2'h1, 2'h1, 8'h01);
      wr(2'b00, 2'h1, 2'h1, 8'h00);
      repeat (3) @(negedge clk);
      chk("target_written", {8'hA5, 2'h1}, tgt[19:10]);
      $display("write test done");
   endtask
   task automatic t_pins;
      {src, ptr, route, dec} = {4'hF, 8'hE4, 8'hE4, 8'hE4};
      for (m = 3; m < 8; m++) begin
         mode = m[2:0];
         for (k = 0; k < 16; k++) begin
            pin_req <= {k[2:0], k[3:0]};
            pg = k[1:0];
            repeat (7) @(negedge clk);
            chk("active", exp_act(m, k[3:0], k[2:0]), act);
            chk("pin_oe", (m == 4) ? 4'hC : 4'h0, mp_oe);
            chk("pin_out", (m == 4) ? {k[1:0], 2'h0} : 4'h0, mp_out);
         end
      end
      src = 4'h0;
      repeat (3) @(negedge clk);
      chk("pointer_source", 8'hE4, act);
      $display("pin select test done");
   endtask
   task automatic t_ramp;
      {fbd, pup, fall, ptr, en} = {8'h01, 12'h001, 12'h002, 8'h01, 4'h1};
      gap(16);
      idle(code(1));
      ptr = 8'h03;
      gap(8);
      idle(code(3));
      ptr = 8'h00;
      gap(32);
      idle(code(0));
      en = 4'h0;
      gap(8);
      idle(10'h000);
      $display("ramp test done");
   endtask
   task automatic t_wdog;
      integer r;
      mask = 4'h8;
      wr(2'b10, 2'h3, 2'h0, 8'h77);
      wr(2'b01, 2'h3, 2'h0, 8'h00);
      wr(2'b00, 2'h3, 2'h0, 8'h00);
      repeat (3) @(negedge clk);
      chk("target_written", 10'h1DC, tgt[39:30]);
      // Point buck 3 away from setpoint 0 so only the override can bring it back.
      ptr = 8'hC0;
      repeat (3) @(negedge clk);
      chk("active_before", 2'h3, act[7:6]);
      // A short low pulse must be ignored; a long one restores exactly once.
      for (m = 0; m < 2; m++) begin
         r = 0;
         wdog_n = 1'b0;
         for (k = 0; k < WDC + 20 * m + 5; k++) begin
            if (k == WDC + 20 * m - 5) wdog_n = 1'b1;
            @(negedge clk);
            if (restore === 1'b1) r++;
         end
         chk("restore_count", m, r);
      end
      chk("target_restored", code(12), tgt[39:30]);
      chk("active_restored", 2'h0, act[7:6]);
      $display("watchdog test done");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {rst_n, wr_hi, wr_lo, boot, wb, wi, wd, pg, mode, src, en, mask} = '0;
      {ptr, route, dec, fbd, pup, pdn, rise, fall, otp} = '0;
      wdog_n = 1'b1;
      pin_req = 7'h00;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      t_boot;
      t_write;
      t_pins;
      t_ramp;
      t_wdog;
      end_sim;
   end
   initial begin
      #200000;
      num_errors++;
      $display("ERROR run expected finish got timeout");
      end_sim;
   end
endmodule  // dss_setpoint_selector_tb
`default_nettype wire
